/* File: pin_synchronizer.v */
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes a free-running clk; the first stage feeds only the second.
module pin_synchronizer #(
	parameter WIDTH = 2
) (
	input wire clk,
	input wire reset_n,
	input wire clk_en,
	input wire [WIDTH-1:0] pin_level,
	output reg [WIDTH-1:0] synced_level
);

	reg [WIDTH-1:0] meta_stage;

	// ********************************
	// Two stages, cleared on reset
	// ********************************
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_stage <= {WIDTH{1'b0}};
			synced_level <= {WIDTH{1'b0}};
		end else if (clk_en) begin
			meta_stage <= pin_level;
			synced_level <= meta_stage;
		end
	end

endmodule // pin_synchronizer

/* File: regulator_two_enable_control.v */
// Enable, discharge, mode and voltage-code control for the second linear regulator.
// Assumes a simple internal byte register port on clk, boot timer milestones and
// power-state flags on clk, and the two multipurpose inputs arriving from pins.
//
// Notes on behaviour
// RQ1 - Slot is read-only 3 bits; 000 stays off, 001 on while supply present.
// RQ2 - Slots 010, 011, 100 enable at boot timer 0%, 25%, 50%.
// RQ3 - Slots 101, 110 stay off; 111 hands over to software after full span.
// RQ4 - Software enable selection is ignored unless the slot reads 111.
// RQ5 - Selection 00 disables; discharge then only in restart, shutdown or off.
// RQ6 - Selection 01 always on; 10 follows input zero regardless of input one.
// RQ7 - Selection 11 follows input one regardless of input zero.
// RQ8 - Discharge bit 0: restart, shutdown or off only; bit 1: also whenever enable falls low.
// RQ9 - Mode 0 regulates; mode 1 makes the pass device a plain on/off switch.
// RQ10 - Mode bit is latched and only takes effect while the regulator is off.
// RQ11 - Voltage register holds a 5-bit code, upper bits read zero, read/write.
// RQ12 - All sources merge into one enable, forced low in restart, shutdown, off.
`include "regulator_two_map.vh"

module regulator_two_enable_control (
	input wire clk,
	input wire rstn,
	input wire clk_en,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	input wire [2:0] sequence_strap,
	input wire supply_present,
	input wire boot_reached_0,
	input wire boot_reached_25,
	input wire boot_reached_50,
	input wire boot_reached_100,
	input wire forced_restart_state,
	input wire shutdown_state,
	input wire off_state,
	input wire multipurpose_input_zero,
	input wire multipurpose_input_one,
	output reg [7:0] reg_rdata,
	output reg regulator_enable,
	output reg regulator_switch_active,
	output reg output_discharge,
	output reg [4:0] regulator_two_voltage_code
);

	reg rst_meta;
	reg rst_sync;
	reg strap_taken;
	reg [2:0] regulator_two_sequence_slot;
	reg regulator_two_active_discharge;
	reg [1:0] regulator_two_enable_select;
	reg regulator_two_switch_mode;
	reg next_enable;
	reg next_discharge;
	reg [7:0] next_rdata;
	wire [1:0] synced_inputs;
	wire forced_off;
	wire [7:0] config_image;
	wire software_off;

	// ********************************
	// Address decode
	// ********************************
	// Shared by the write path and the read mux
	// so the two can never decode an offset differently
	function hits_config(input [7:0] addr);
		hits_config = (addr == `REG_TWO_CONFIG_ADDR);
	endfunction

	// Voltage register decode, same reason
	function hits_voltage(input [7:0] addr);
		hits_voltage = (addr == `REG_TWO_VOLTAGE_ADDR);
	endfunction

	// ********************************
	// Reset release
	// ********************************
	// Async assert, release through two flops so all state leaves reset together
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else if (clk_en) begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// Pin inputs come from outside the clock domain
	pin_synchronizer #(
		.WIDTH(2)
	) i_pin_synchronizer (
		.clk(clk),
		.reset_n(rst_sync),
		.clk_en(clk_en),
		.pin_level({multipurpose_input_one, multipurpose_input_zero}),
		.synced_level(synced_inputs)
	);

	// ********************************
	// Sequencing slot capture
	// ********************************
	// Strap sampled once after release; an async load of a port is not allowed
	// A strap change after release is ignored until the next reset
	always @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			strap_taken <= 1'b0;
			regulator_two_sequence_slot <= `SEQ_OFF;
		end else if (clk_en && !strap_taken) begin
			strap_taken <= 1'b1;
			regulator_two_sequence_slot <= sequence_strap; // [RQ1]
		end
	end

	// ********************************
	// Software registers
	// ********************************
	// Slot and reserved bit ignore writes; only the low field bits are stored
	always @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			regulator_two_active_discharge <= `RESET_DISCHARGE;
			regulator_two_enable_select <= `RESET_ENSEL;
			regulator_two_switch_mode <= `RESET_MODE;
			regulator_two_voltage_code <= `RESET_VOLTAGE;
		end else if (clk_en && reg_write) begin
			if (hits_config(reg_addr)) begin
				regulator_two_active_discharge <= reg_wdata[`CFG_DISCHARGE_BIT];
				regulator_two_enable_select <= reg_wdata[`CFG_ENSEL_HI:`CFG_ENSEL_LO];
				regulator_two_switch_mode <= reg_wdata[`CFG_MODE_BIT];
			end else if (hits_voltage(reg_addr)) begin
				regulator_two_voltage_code <= reg_wdata[`VOLT_HI:`VOLT_LO]; // [RQ11]
			end
		end
	end

	// Config read image; the reserved bit always reads zero
	assign config_image = {regulator_two_sequence_slot, 1'b0, regulator_two_active_discharge,
		regulator_two_enable_select, regulator_two_switch_mode};

	// Read mux; unmapped offsets and unused bits read zero
	always @* begin
		next_rdata = 8'h00;
		if (hits_config(reg_addr)) begin
			next_rdata = config_image; // [RQ1]
		end else if (hits_voltage(reg_addr)) begin
			next_rdata = {3'h0, regulator_two_voltage_code}; // [RQ11]
		end
	end

	// Read data held until the next read strobe
	always @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			reg_rdata <= 8'h00;
		end else if (clk_en && reg_read) begin
			reg_rdata <= next_rdata;
		end
	end

	// ********************************
	// Effective enable
	// ********************************
	// Any power-down state overrides every enable source
	assign forced_off = forced_restart_state | shutdown_state | off_state;

	// Software slot with selection 00 parks the rail without discharge
	assign software_off = (regulator_two_sequence_slot == `SEQ_SOFTWARE) &&
		(regulator_two_enable_select == `ENSEL_OFF); // [RQ5]

	// Slot decides first; selection only matters under the software slot
	always @* begin
		next_enable = 1'b0;
		case (regulator_two_sequence_slot)
			`SEQ_SUPPLY: next_enable = supply_present; // [RQ1]
			`SEQ_AT_0: next_enable = boot_reached_0; // [RQ2]
			`SEQ_AT_25: next_enable = boot_reached_25; // [RQ2]
			`SEQ_AT_50: next_enable = boot_reached_50; // [RQ2]
			`SEQ_SOFTWARE: begin
				if (boot_reached_100) begin // [RQ3] [RQ4]
					case (regulator_two_enable_select)
						`ENSEL_ON: next_enable = 1'b1; // [RQ6]
						`ENSEL_INPUT_ZERO: next_enable = synced_inputs[0]; // [RQ6]
						`ENSEL_INPUT_ONE: next_enable = synced_inputs[1]; // [RQ7]
						default: next_enable = 1'b0; // [RQ5]
					endcase
				end
			end
			default: next_enable = 1'b0; // [RQ1] [RQ3]
		endcase
		if (forced_off) begin
			next_enable = 1'b0; // [RQ12]
		end
	end

	// Discharge in forced-off states, or on any low enable when the option is set
	// A rail parked by software selection 00 is left undischarged on purpose
	always @* begin
		next_discharge = forced_off; // [RQ5] [RQ8]
		if (regulator_two_active_discharge && !next_enable && !software_off) begin // [RQ5]
			next_discharge = 1'b1; // [RQ8]
		end
	end

	// ********************************
	// Outputs and mode latch
	// ********************************
	// Mode only follows the register while off, so a live rail never changes type
	// Discharge resets high so the rail is pulled down until control is valid
	always @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			regulator_enable <= 1'b0;
			output_discharge <= 1'b1;
			regulator_switch_active <= `RESET_MODE;
		end else if (clk_en) begin
			regulator_enable <= next_enable; // [RQ12]
			output_discharge <= next_discharge;
			if (!regulator_enable) begin
				regulator_switch_active <= regulator_two_switch_mode; // [RQ9] [RQ10]
			end
		end
	end

endmodule // regulator_two_enable_control

/* File: regulator_two_enable_control_tb.sv */
// Self-checking bench for the second regulator control.
// Assumes the design and its bound checker are compiled before this file.
module regulator_two_enable_control_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rstn = 0, clk_en = 1, reg_write = 0, reg_read = 0, supply_present = 1;
	logic boot_reached_0 = 1, boot_reached_25 = 0, boot_reached_50 = 0, boot_reached_100 = 1;
	logic forced_restart_state = 0, shutdown_state = 0, off_state = 0;
	logic multipurpose_input_zero = 0, multipurpose_input_one = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	logic [2:0] sequence_strap = 3'h7;
	wire [7:0] reg_rdata;
	wire regulator_enable, regulator_switch_active, output_discharge;
	wire [4:0] regulator_two_voltage_code;
	int n_errors = 0, checks = 0;
	regulator_two_enable_control i_regulator_two_enable_control (
		.clk(clk),
		.rstn(rstn),
		.clk_en(clk_en),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.sequence_strap(sequence_strap),
		.supply_present(supply_present),
		.boot_reached_0(boot_reached_0),
		.boot_reached_25(boot_reached_25),
		.boot_reached_50(boot_reached_50),
		.boot_reached_100(boot_reached_100),
		.forced_restart_state(forced_restart_state),
		.shutdown_state(shutdown_state),
		.off_state(off_state),
		.multipurpose_input_zero(multipurpose_input_zero),
		.multipurpose_input_one(multipurpose_input_one),
		.reg_rdata(reg_rdata),
		.regulator_enable(regulator_enable),
		.regulator_switch_active(regulator_switch_active),
		.output_discharge(output_discharge),
		.regulator_two_voltage_code(regulator_two_voltage_code)
	);
	always #12.5 clk = ~clk;
	// ****************
	// Shared tasks
	// ****************
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [7:0] g, e);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %0t got %h want %h", $time, g, e);
		end
	endtask
	// Slot is only sampled after reset, so each slot costs a reset
	task do_reset(input logic [2:0] s);
		@(posedge clk);
		rstn <= 0;
		sequence_strap <= s;
		repeat (8) @(posedge clk);
		rstn <= 1;
		repeat (6) @(posedge clk);
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge clk);
		{reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
		@(posedge clk);
		reg_write <= 0;
	endtask
	task rd(input logic [7:0] a, e);
		@(posedge clk);
		{reg_addr, reg_read} <= {a, 1'b1};
		@(posedge clk);
		reg_read <= 0;
		#1 chk(reg_rdata, e);
	endtask
	// Five edges cover the three-stage pin path
	task outs(input logic en, dis, sw);
		repeat (5) @(posedge clk);
		#1 chk({regulator_enable, output_discharge, regulator_switch_active}, {en, dis, sw});
	endtask
	// ****************
	// Scenarios
	// ****************
	task t_slots;
		for (int s = 0; s < 7; s++) begin
			do_reset(s[2:0]);
			rd(8'h15, 8'h00);
			wr(8'h14, 8'h02);
			outs(s == 1 || s == 2, 0, 0);
			// Swap milestones: supply and 0% low, 25% and 50% high
			@(posedge clk);
			{supply_present, boot_reached_0, boot_reached_25, boot_reached_50} <= 4'h3;
			outs(s == 3 || s == 4, 0, 0);
			@(posedge clk);
			{supply_present, boot_reached_0, boot_reached_25, boot_reached_50} <= 4'hc;
			rd(8'h14, {s[2:0], 5'h02});
		end
		$display("slot test done");
	endtask
	task t_ensel;
		do_reset(3'h7);
		for (int e = 0; e < 4; e++)
			for (int p = 0; p < 4; p++) begin
				@(posedge clk);
				{multipurpose_input_one, multipurpose_input_zero} <= p[1:0];
				wr(8'h14, {5'h01, e[1:0], 1'b0});
				outs(e == 1 || (e == 2 && p[0]) || (e == 3 && p[1]),
					e != 0 && !(e == 1 || (e == 2 && p[0]) || (e == 3 && p[1])), 0);
			end
		wr(8'h14, 8'h02);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			{forced_restart_state, shutdown_state, off_state} <= 3'h4 >> k;
			outs(0, 1, 0);
			@(posedge clk);
			{forced_restart_state, shutdown_state, off_state} <= 3'h0;
			outs(1, 0, 0);
		end
		// Software selection only counts once the full span is reached
		@(posedge clk);
		boot_reached_100 <= 0;
		outs(0, 0, 0);
		@(posedge clk);
		boot_reached_100 <= 1;
		outs(1, 0, 0);
		$display("enable test done");
	endtask
	task t_mode;
		wr(8'h14, 8'h03);
		outs(1, 0, 0);
		wr(8'h14, 8'h01);
		outs(0, 0, 1);
		wr(8'h14, 8'h03);
		outs(1, 0, 1);
		wr(8'h14, 8'h00);
		outs(0, 0, 0);
		$display("mode test done");
	endtask
	task t_regs;
		rd(8'h14, 8'he0);
		wr(8'h14, 8'hff);
		rd(8'h14, 8'hef);
		wr(8'h15, 8'hff);
		#1 chk({3'h0, regulator_two_voltage_code}, 8'h1f);
		rd(8'h15, 8'h1f);
		wr(8'h15, 8'h0a);
		#1 chk({3'h0, regulator_two_voltage_code}, 8'h0a);
		rd(8'h15, 8'h0a);
		rd(8'h16, 8'h00);
		// Clock enable low: strobes are dropped and read data holds
		@(posedge clk);
		clk_en <= 0;
		wr(8'h15, 8'h11);
		rd(8'h15, 8'h00);
		#1 chk({3'h0, regulator_two_voltage_code}, 8'h0a);
		@(posedge clk);
		clk_en <= 1;
		rd(8'h15, 8'h0a);
		$display("register test done");
	endtask
	initial begin
		t_slots();
		t_ensel();
		t_mode();
		t_regs();
		report_and_stop();
	end
	// Hang guard
	initial begin
		#200000;
		n_errors++;
		report_and_stop();
	end
endmodule // regulator_two_enable_control_tb

/* File: regulator_two_map.vh */
// Register offsets, field positions and reset values for the second regulator control.
// Assumes inclusion by regulator_two_enable_control.v only; definitions only.
`ifndef REGULATOR_TWO_MAP_VH
`define REGULATOR_TWO_MAP_VH

// ********************************
// Register offsets
// ********************************
`define REG_TWO_CONFIG_ADDR 8'h14
`define REG_TWO_VOLTAGE_ADDR 8'h15

// ********************************
// Configuration register fields
// ********************************
`define CFG_SEQ_HI 7
`define CFG_SEQ_LO 5
`define CFG_RESERVED_BIT 4
`define CFG_DISCHARGE_BIT 3
`define CFG_ENSEL_HI 2
`define CFG_ENSEL_LO 1
`define CFG_MODE_BIT 0

// ********************************
// Codes and reset values
// ********************************
`define SEQ_OFF 3'h0
`define SEQ_SUPPLY 3'h1
`define SEQ_AT_0 3'h2
`define SEQ_AT_25 3'h3
`define SEQ_AT_50 3'h4
`define SEQ_SOFTWARE 3'h7
`define ENSEL_OFF 2'h0
`define ENSEL_ON 2'h1
`define ENSEL_INPUT_ZERO 2'h2
`define ENSEL_INPUT_ONE 2'h3
`define RESET_DISCHARGE 1'h0
`define RESET_ENSEL 2'h0
`define RESET_MODE 1'h0
`define RESET_VOLTAGE 5'h00
`define VOLT_HI 4
`define VOLT_LO 0
`define SYNC_STAGES 2

`endif

/* File: regulator_two_monitor.sv */
// Port-level checker for the second regulator control.
// Assumes bind to regulator_two_enable_control; clk_en low pauses checking.
module regulator_two_monitor (
	input wire clk,
	input wire rstn,
	input wire clk_en,
	input wire reg_write,
	input wire reg_read,
	input wire supply_present,
	input wire boot_reached_0,
	input wire boot_reached_25,
	input wire boot_reached_50,
	input wire boot_reached_100,
	input wire forced_restart_state,
	input wire shutdown_state,
	input wire off_state,
	input wire multipurpose_input_zero,
	input wire multipurpose_input_one,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	input wire [2:0] sequence_strap,
	input wire regulator_enable,
	input wire regulator_switch_active,
	input wire output_discharge,
	input wire [4:0] regulator_two_voltage_code
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************
	// Assertions
	// ****************
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn || !clk_en);
	// Any of the three power-down states
	wire forced = forced_restart_state | shutdown_state | off_state;
	sequence s_read_volt;
		reg_read && !reg_write && reg_addr == 8'h15;
	endsequence
	a_forced_enable_low: assert property (forced |=> !regulator_enable)
		else $error("enable high in forced state");
	a_forced_discharge: assert property (forced |=> output_discharge)
		else $error("no discharge in forced state");
	a_on_no_discharge: assert property (regulator_enable |-> !output_discharge)
		else $error("discharge while enabled");
	a_mode_latch_off: assert property ($changed(regulator_switch_active) |-> !$past(regulator_enable))
		else $error("mode changed while enabled");
	a_volt_read_back: assert property (s_read_volt |=> reg_rdata == {3'h0, regulator_two_voltage_code})
		else $error("voltage read wrong");
	a_volt_write: assert property (reg_write && reg_addr == 8'h15 |=>
		{3'h0, regulator_two_voltage_code} == ($past(reg_wdata) & 8'h1f))
		else $error("voltage write lost");
	a_unmapped_zero: assert property (reg_read && reg_addr != 8'h14 && reg_addr != 8'h15 |=>
		reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_reserved_zero: assert property (reg_read && reg_addr == 8'h14 |=> !reg_rdata[4])
		else $error("reserved bit set");
	a_rdata_hold: assert property (!reg_read |=> $stable(reg_rdata))
		else $error("read data moved");
endmodule // regulator_two_monitor

bind regulator_two_enable_control regulator_two_monitor i_regulator_two_monitor (
	.clk(clk),
	.rstn(rstn),
	.clk_en(clk_en),
	.reg_write(reg_write),
	.reg_read(reg_read),
	.supply_present(supply_present),
	.boot_reached_0(boot_reached_0),
	.boot_reached_25(boot_reached_25),
	.boot_reached_50(boot_reached_50),
	.boot_reached_100(boot_reached_100),
	.forced_restart_state(forced_restart_state),
	.shutdown_state(shutdown_state),
	.off_state(off_state),
	.multipurpose_input_zero(multipurpose_input_zero),
	.multipurpose_input_one(multipurpose_input_one),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.sequence_strap(sequence_strap),
	.regulator_enable(regulator_enable),
	.regulator_switch_active(regulator_switch_active),
	.output_discharge(output_discharge),
	.regulator_two_voltage_code(regulator_two_voltage_code)
);
